// file: logic/qd_encoder_top.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Functional notes
// RQ1 - Codes 001/010: x2 counting, index or limit reset
// RQ2 - Codes 101/110: x4 counting, index or limit reset
// RQ3 - Capture inputs usable only with mode 000
// RQ4 - Decoder wins when both units enabled
// RQ5 - Each pin filter feeds only active unit
// RQ6 - Decoder remaps buffers: velocity, position, limit
// RQ7 - Channel one buffer becomes velocity result
// RQ8 - Sixteen bit up/down position count
// RQ9 - x2 counts A edges, x4 both phases
// RQ10 - Count reset by limit rollover or index
// RQ11 - Count reset raises enabled position flag
// RQ12 - Control logic makes direction, count, velocity pulses
// RQ13 - Direction change raises its own flag
// RQ14 - Velocity flag lives in flag register
// RQ15 - Bit 5 reads 1 forward, 0 reverse
// RQ16 - Bit 6 sticky overflow/underflow, software clears
// RQ17 - Error and direction meaningful in index modes
// RQ18 - Bit 7 high disables velocity measurement
// RQ19 - Ratio codes give 1:1, 1:4, 1:16, 1:64
// RQ20 - One output per N inputs, width kept
// RQ21 - A leads B: up; A lags: down
// RQ22 - Index: forward clears, reverse loads limit
// RQ23 - Period reverse at zero loads limit, flag later
// RQ24 - Unused mode codes keep decoder disabled
// RQ25 - Control fields reset to zero
module qd_encoder_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [qd_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [qd_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [qd_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [qd_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  output logic capture_unit_enable,
  output logic [2:0] capture_inputs,
  output logic velocity_event
);
  import qd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic ctl_vel_disable_reg; // Velocity measurement off
  logic ctl_error_reg; // Sticky count wrap in index mode
  logic ctl_dir_reg; // Direction status, 1 forward
  logic [2:0] ctl_mode_reg; // Decoder mode field
  logic [1:0] ctl_ratio_reg; // Velocity ratio field
  logic [15:0] position_count_reg;
  logic [15:0] position_limit_reg;
  logic [15:0] velocity_result_reg;
  logic vel_flag_reg;
  logic pos_flag_reg;
  logic dir_flag_reg;
  logic pos_irq_enable_reg;
  logic capture_request_reg; // Software asks for the capture unit
  // Decoder state
  logic a_prev_reg;
  logic b_prev_reg;
  logic idx_prev_reg;
  logic idx_fwd_pend_reg; // Index rise waiting for forward edge
  logic idx_rev_pend_reg; // Index fall waiting for reverse edge
  logic roll_pend_reg; // Period match reached, rollover next
  logic roll_dir_reg; // Direction of that match
  logic irq_pipe_reg; // Position flag one cycle after reset
  logic [15:0] position_next;
  // Bus slave state
  logic [AXI_ADDR_W-1:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Input noise filters, one per shared pin
  wire [2:0] pin_raw = {phase_b_input, phase_a_input, index_input};
  logic [2:0] filt;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filter
      logic [FILT_LEN-1:0] hist_reg;
      logic out_reg;
      // Output moves only after all samples agree
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hist_reg <= '0;
          out_reg <= 1'b0;
        end else begin
          hist_reg <= {hist_reg[FILT_LEN-2:0], pin_raw[gi]};
          if (&hist_reg) begin
            out_reg <= 1'b1;
          end else if (~|hist_reg) begin
            out_reg <= 1'b0;
          end
        end
      end
      assign filt[gi] = out_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode and pin ownership
  wire decoder_active = (ctl_mode_reg == MODE_X2_INDEX) | (ctl_mode_reg == MODE_X2_PERIOD) |
                        (ctl_mode_reg == MODE_X4_INDEX) | (ctl_mode_reg == MODE_X4_PERIOD); // RQ24
  wire quad4 = (ctl_mode_reg == MODE_X4_INDEX) | (ctl_mode_reg == MODE_X4_PERIOD); // RQ2
  wire index_mode = (ctl_mode_reg == MODE_X2_INDEX) | (ctl_mode_reg == MODE_X4_INDEX); // RQ1
  wire period_mode = (ctl_mode_reg == MODE_X2_PERIOD) | (ctl_mode_reg == MODE_X4_PERIOD); // RQ1
  // Capture only with mode 000; the decoder wins otherwise
  assign capture_unit_enable = capture_request_reg & (ctl_mode_reg == MODE_OFF); // RQ3 RQ4
  // Filtered pins go to the owning unit only
  assign capture_inputs = capture_unit_enable ? filt : 3'h0; // RQ5

  ////////////////////////////////////////////////////////////////////////////////
  // Edge and phase detection
  wire a_now = filt[1];
  wire b_now = filt[2];
  wire idx_now = filt[0];
  wire a_edge = decoder_active & (a_now ^ a_prev_reg);
  wire b_edge = decoder_active & (b_now ^ b_prev_reg);
  wire count_pulse = a_edge | (quad4 & b_edge); // RQ9 RQ12
  // A edge: up when A differs from B; B edge: up when they match
  wire edge_up = a_edge ? (a_now ^ b_now) : ~(a_now ^ b_now); // RQ21
  wire dir_change = count_pulse & (edge_up != ctl_dir_reg); // RQ13
  wire idx_rise = decoder_active & index_mode & idx_now & ~idx_prev_reg; // RQ12
  wire idx_fall = decoder_active & index_mode & ~idx_now & idx_prev_reg;
  wire index_hit = count_pulse & index_mode &
                   ((edge_up & idx_fwd_pend_reg) | (~edge_up & idx_rev_pend_reg)); // RQ22
  wire [15:0] pos_plus = position_count_reg + COUNT_ONE;
  wire [15:0] pos_minus = position_count_reg - COUNT_ONE;
  wire match_hit = count_pulse & period_mode &
                   ((edge_up & (pos_plus == position_limit_reg)) |
                    (~edge_up & (pos_minus == COUNT_RESET))); // RQ10
  wire wrap_hit = count_pulse & index_mode & ~index_hit &
                  ((edge_up & (position_count_reg == COUNT_MAX)) |
                   (~edge_up & (position_count_reg == COUNT_RESET))); // RQ16 RQ17
  wire pos_reset_evt = roll_pend_reg | index_hit; // RQ10
  wire vel_pulse = count_pulse & ~ctl_vel_disable_reg; // RQ18

  ////////////////////////////////////////////////////////////////////////////////
  // Velocity postscaler
  qd_velocity_postscaler u_postscaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .pulse_in(vel_pulse),
    .ratio(ctl_ratio_reg),
    .pulse_out(velocity_event)
  ); // RQ19 RQ20

  ////////////////////////////////////////////////////////////////////////////////
  // Bus write decode
  wire do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire wr_b0 = do_wr & wr_strb_reg[0];
  wire wr_ctl = wr_b0 & (wr_addr_reg == OFF_CONTROL);
  wire wr_pos = do_wr & (wr_addr_reg == OFF_POSITION) & (|wr_strb_reg[1:0]);
  wire wr_lim = do_wr & (wr_addr_reg == OFF_LIMIT) & (|wr_strb_reg[1:0]);
  wire wr_flags = wr_b0 & (wr_addr_reg == OFF_FLAGS);
  wire wr_irq_en = wr_b0 & (wr_addr_reg == OFF_IRQ_ENABLE);
  wire wr_cap = wr_b0 & (wr_addr_reg == OFF_CAPTURE);
  wire wr_mapped = (wr_addr_reg == OFF_CONTROL) | (wr_addr_reg == OFF_VELOCITY) |
                   (wr_addr_reg == OFF_POSITION) | (wr_addr_reg == OFF_LIMIT) |
                   (wr_addr_reg == OFF_FLAGS) | (wr_addr_reg == OFF_IRQ_ENABLE) |
                   (wr_addr_reg == OFF_CAPTURE);
  // Byte-lane merge for the 16-bit registers
  wire [15:0] pos_wdata = {wr_strb_reg[1] ? wr_data_reg[15:8] : position_count_reg[15:8],
                           wr_strb_reg[0] ? wr_data_reg[7:0] : position_count_reg[7:0]};
  wire [15:0] lim_wdata = {wr_strb_reg[1] ? wr_data_reg[15:8] : position_limit_reg[15:8],
                           wr_strb_reg[0] ? wr_data_reg[7:0] : position_limit_reg[7:0]};
  wire err_clear = wr_ctl & ~wr_data_reg[CTL_ERROR_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Position count next value: software, rollover, index, count
  always_comb begin
    position_next = position_count_reg;
    if (wr_pos) begin
      position_next = pos_wdata;
    end else if (roll_pend_reg) begin
      position_next = roll_dir_reg ? COUNT_RESET : position_limit_reg; // RQ23
    end else if (index_hit) begin
      position_next = edge_up ? COUNT_RESET : position_limit_reg; // RQ22
    end else if (count_pulse) begin
      position_next = edge_up ? pos_plus : pos_minus; // RQ8 RQ21
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_vel_disable_reg <= 1'b0; // RQ25
      ctl_mode_reg <= MODE_RESET;
      ctl_ratio_reg <= RATIO_RESET;
      ctl_error_reg <= 1'b0;
      ctl_dir_reg <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_vel_disable_reg <= wr_data_reg[CTL_VEL_DISABLE_BIT]; // RQ18
        ctl_mode_reg <= wr_data_reg[CTL_MODE_LSB+:3];
        ctl_ratio_reg <= wr_data_reg[CTL_RATIO_LSB+:2];
      end
      // Set wins over a software clear
      ctl_error_reg <= wrap_hit | (ctl_error_reg & ~err_clear); // RQ16
      if (count_pulse) begin
        ctl_dir_reg <= edge_up; // RQ15
      end
    end
  end

  // Position, limit and velocity result registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position_count_reg <= COUNT_RESET;
      position_limit_reg <= LIMIT_RESET;
      velocity_result_reg <= COUNT_RESET;
    end else begin
      position_count_reg <= position_next; // RQ6
      if (wr_lim) begin
        position_limit_reg <= lim_wdata;
      end
      if (velocity_event) begin
        velocity_result_reg <= velocity_result_reg + COUNT_ONE; // RQ7
      end
    end
  end

  // Decoder sequencing state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      idx_prev_reg <= 1'b0;
      idx_fwd_pend_reg <= 1'b0;
      idx_rev_pend_reg <= 1'b0;
      roll_pend_reg <= 1'b0;
      roll_dir_reg <= 1'b0;
      irq_pipe_reg <= 1'b0;
    end else begin
      a_prev_reg <= a_now;
      b_prev_reg <= b_now;
      idx_prev_reg <= idx_now;
      // Pending index marks wait for the next quadrature edge
      idx_fwd_pend_reg <= idx_rise | (idx_fwd_pend_reg & ~count_pulse & index_mode);
      idx_rev_pend_reg <= idx_fall | (idx_rev_pend_reg & ~count_pulse & index_mode);
      roll_pend_reg <= match_hit; // RQ23
      roll_dir_reg <= edge_up;
      irq_pipe_reg <= pos_reset_evt & pos_irq_enable_reg; // RQ11
    end
  end

  // Flags, enable and capture request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vel_flag_reg <= 1'b0;
      pos_flag_reg <= 1'b0;
      dir_flag_reg <= 1'b0;
      pos_irq_enable_reg <= 1'b0;
      capture_request_reg <= 1'b0;
    end else begin
      vel_flag_reg <= velocity_event |
                      (vel_flag_reg & ~(wr_flags & wr_data_reg[FLAG_VEL_BIT])); // RQ14
      pos_flag_reg <= irq_pipe_reg |
                      (pos_flag_reg & ~(wr_flags & wr_data_reg[FLAG_POS_BIT])); // RQ11
      dir_flag_reg <= dir_change |
                      (dir_flag_reg & ~(wr_flags & wr_data_reg[FLAG_DIR_BIT])); // RQ13
      if (wr_irq_en) begin
        pos_irq_enable_reg <= wr_data_reg[IRQ_EN_POS_BIT];
      end
      if (wr_cap) begin
        capture_request_reg <= wr_data_reg[CAPTURE_REQ_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus write channels: address and data taken in either order
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready = ~w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid & ~aw_full_reg) begin
        aw_full_reg <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid & ~w_full_reg) begin
        w_full_reg <= 1'b1;
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus read channel
  wire [AXI_ADDR_W-1:0] ra = s_axi_araddr;
  wire [7:0] ctl_read = {ctl_vel_disable_reg, ctl_error_reg, ctl_dir_reg,
                         ctl_mode_reg, ctl_ratio_reg};
  wire rd_mapped = (ra == OFF_CONTROL) | (ra == OFF_VELOCITY) | (ra == OFF_POSITION) |
                   (ra == OFF_LIMIT) | (ra == OFF_FLAGS) | (ra == OFF_IRQ_ENABLE) |
                   (ra == OFF_CAPTURE);
  wire [31:0] rd_mux =
    (ra == OFF_CONTROL) ? {24'h000000, ctl_read} :
    (ra == OFF_VELOCITY) ? {16'h0000, velocity_result_reg} :
    (ra == OFF_POSITION) ? {16'h0000, position_count_reg} :
    (ra == OFF_LIMIT) ? {16'h0000, position_limit_reg} :
    (ra == OFF_FLAGS) ? {29'h00000000, dir_flag_reg, pos_flag_reg, vel_flag_reg} :
    (ra == OFF_IRQ_ENABLE) ? {30'h00000000, pos_irq_enable_reg, 1'b0} :
    (ra == OFF_CAPTURE) ? {31'h00000000, capture_request_reg} : 32'h00000000;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid & ~rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_capture_owner;
    @(posedge aclk) disable iff (!aresetn)
      capture_unit_enable |-> (ctl_mode_reg == MODE_OFF) && !decoder_active;
  endproperty
  a_capture_owner: assert property (p_capture_owner) else $error("capture with decoder on"); // RQ3

  property p_pins_exclusive;
    @(posedge aclk) disable iff (!aresetn)
      (capture_request_reg && decoder_active) |-> (capture_inputs == 3'h0);
  endproperty
  a_pins_exclusive: assert property (p_pins_exclusive) else $error("pins shared"); // RQ4

  property p_count_up;
    @(posedge aclk) disable iff (!aresetn)
      (count_pulse && edge_up && !wr_pos && !roll_pend_reg && !index_hit) |=>
        (position_count_reg == $past(position_count_reg) + COUNT_ONE);
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not step up"); // RQ21

  property p_x2_ignores_b;
    @(posedge aclk) disable iff (!aresetn)
      (!quad4 && b_edge && !a_edge) |-> !count_pulse;
  endproperty
  a_x2_ignores_b: assert property (p_x2_ignores_b) else $error("x2 counted B edge"); // RQ9

  property p_index_forward;
    @(posedge aclk) disable iff (!aresetn)
      (index_hit && edge_up && !wr_pos && !roll_pend_reg) |=> (position_count_reg == 16'h0000);
  endproperty
  a_index_forward: assert property (p_index_forward) else $error("index did not clear"); // RQ22

  property p_period_reverse;
    @(posedge aclk) disable iff (!aresetn)
      (match_hit && !edge_up && pos_irq_enable_reg && !wr_pos && !roll_pend_reg && !wr_lim)
        |=> ##1 (position_count_reg == $past(position_limit_reg)) ##1 pos_flag_reg;
  endproperty
  a_period_reverse: assert property (p_period_reverse) else $error("reverse load late"); // RQ23

  property p_error_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (ctl_error_reg && !err_clear) |=> ctl_error_reg;
  endproperty
  a_error_sticky: assert property (p_error_sticky) else $error("error bit lost"); // RQ16

  property p_dir_flag;
    @(posedge aclk) disable iff (!aresetn) dir_change |=> dir_flag_reg;
  endproperty
  a_dir_flag: assert property (p_dir_flag) else $error("direction flag missed"); // RQ13

  property p_idle_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!decoder_active && !wr_pos && !roll_pend_reg) |=> $stable(position_count_reg);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved while off"); // RQ24

  property p_index_flag;
    @(posedge aclk) disable iff (!aresetn)
      (index_hit && pos_irq_enable_reg) |=> ##1 pos_flag_reg;
  endproperty
  a_index_flag: assert property (p_index_flag) else $error("position flag missed"); // RQ11
endmodule

// file: logic/qd_pkg.sv
package qd_pkg;
  // Bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_VELOCITY = 8'h04;
  localparam logic [7:0] OFF_POSITION = 8'h08;
  localparam logic [7:0] OFF_LIMIT = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFF_CAPTURE = 8'h18;
  ////////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTL_VEL_DISABLE_BIT = 7;
  localparam int CTL_ERROR_BIT = 6;
  localparam int CTL_DIR_BIT = 5;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_RATIO_LSB = 0;
  // Flag register fields, enable and capture request bits
  localparam int FLAG_VEL_BIT = 0;
  localparam int FLAG_POS_BIT = 1;
  localparam int FLAG_DIR_BIT = 2;
  localparam int IRQ_EN_POS_BIT = 1;
  localparam int CAPTURE_REQ_BIT = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [1:0] RATIO_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  // Decoder mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_X2_INDEX = 3'h1;
  localparam logic [2:0] MODE_X2_PERIOD = 3'h2;
  localparam logic [2:0] MODE_X4_INDEX = 3'h5;
  localparam logic [2:0] MODE_X4_PERIOD = 3'h6;
  // Postscaler last count per ratio code: 1:1, 1:4, 1:16, 1:64
  localparam logic [5:0] VEL_RATIO_LAST [0:3] = '{6'h00, 6'h03, 6'h0F, 6'h3F};
  // Noise filter length in clock samples
  localparam int FILT_LEN = 3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage

// file: logic/qd_velocity_postscaler.sv
`timescale 1ns/1ps
module qd_velocity_postscaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pulse_in,
  input wire logic [1:0] ratio,
  output logic pulse_out
);
  import qd_pkg::*;

  logic [5:0] count_reg; // Input pulses seen since last output
  logic [5:0] count_next;
  wire [5:0] last_count = VEL_RATIO_LAST[ratio];
  wire at_last = (count_reg >= last_count);

  // Output pulse is the input pulse itself, so the width is kept
  assign pulse_out = pulse_in & at_last;
  assign count_next = at_last ? 6'h00 : count_reg + 6'h01;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 6'h00;
    end else if (pulse_in) begin
      count_reg <= count_next; // RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_width_kept;
    @(posedge aclk) disable iff (!aresetn) pulse_out |-> pulse_in;
  endproperty
  a_width_kept: assert property (p_width_kept) else $error("output without input pulse"); // RQ20

  property p_ratio_four;
    @(posedge aclk) disable iff (!aresetn)
      (pulse_out && ratio == 2'h1 && $stable(ratio)) |-> (count_reg == 6'h03);
  endproperty
  a_ratio_four: assert property (p_ratio_four) else $error("1:4 fired off count"); // RQ19
endmodule

// file: sim/qd_encoder_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Rotary encoder with index, stepping one quadrature state per request
module qd_encoder_model (
  input wire logic aclk,
  input wire logic step,
  input wire logic sdir,
  input wire logic idx_in,
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  // Gray state: 0=00, 1=10, 2=11, 3=01 as {a,b}; rising state means A leads
  logic [1:0] st = 2'h0;
  // Advance or retreat one state per step pulse
  always_ff @(posedge aclk) begin
    if (step) begin
      st <= sdir ? st + 2'h1 : st - 2'h1;
    end
  end
  // Phase levels from state
  assign phase_a = st[0] ^ st[1];
  assign phase_b = st[1];
  // Index marker driven straight through
  assign index = idx_in;
endmodule

// file: sim/quadrature_encoder_interface_tb.sv
`timescale 1ns/1ps
module quadrature_encoder_interface_tb;
  import qd_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic step = 0, sdir = 0, idx_in = 0, awr, wrdy, bv, arr, rv, pa, pb, ix, cue, vev, up;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, d, lfsr = 32'hA805;
  logic [1:0] br, rr, rs;
  logic [2:0] ci, m;
  logic [2:0] um [3] = '{3'h3, 3'h4, 3'h7};
  logic [15:0] p;
  int failures = 0, n_tests = 0, i, n, nv = 0;
  always #5 aclk = ~aclk;
  // Counts postscaled velocity pulses seen on the pin
  always @(posedge aclk) if (vev) nv <= nv + 1;
  qd_encoder_top dut(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .phase_a_input(pa),
    .phase_b_input(pb), .index_input(ix), .capture_unit_enable(cue), .capture_inputs(ci),
    .velocity_event(vev));
  qd_encoder_model enc(.aclk(aclk), .step(step), .sdir(sdir), .idx_in(idx_in), .phase_a(pa),
    .phase_b(pb), .index(ix));
  ////////////////////////////////////////////////////////////////////////////////
  // Pseudo-random source and expected position
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [15:0] exp_pos(input logic [15:0] q, input int k, input logic u);
    return u ? q + 16'(k) : q - 16'(k);
  endfunction
  // Closing report
  task give_verdict;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Value compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // Bounded wait guard
  task tmo(input int k);
    if (k >= 60) begin
      failures++;
      $display("unexpected at %0t: bus wait ran out", $time);
      give_verdict;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Bus write: address and data together, bready held until response
  task wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    logic ta, tw, tb;
    k = 0;
    tb = 0;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!tb && k < 60) begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv;
      rs = br;
      @(posedge aclk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      k++;
    end
    bry <= 0;
    tmo(tb ? 0 : k);
  endtask
  // Bus read into d and rs
  task rdr(input logic [7:0] a);
    int k;
    logic ta, tr;
    k = 0;
    tr = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    while (!tr && k < 60) begin
      @(negedge aclk);
      ta = arv && arr;
      tr = rv;
      d = rd;
      rs = rr;
      @(posedge aclk);
      if (ta) arv <= 0;
      k++;
    end
    rry <= 0;
    tmo(tr ? 0 : k);
  endtask
  // Encoder steps, spaced well past the minimum quadrature period
  task mv(input logic u, input int k);
    repeat (k) begin
      @(posedge aclk);
      step <= 1;
      sdir <= u;
      @(posedge aclk);
      step <= 0;
      repeat (20) @(posedge aclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rdr(OFF_CONTROL);
    chk(d, 32'h0);
    chk(32'(cue), 32'h0);
    rdr(8'h1C);
    chk(32'(rs), 32'(RESP_SLVERR));
    $display("test done: reset");
    // Odd passes count x2, even passes x4; both reset kinds
    for (i = 0; i < 4; i++) begin
      m = i[0] ? (i[1] ? MODE_X2_PERIOD : MODE_X2_INDEX)
               : (i[1] ? MODE_X4_PERIOD : MODE_X4_INDEX);
      wr(OFF_CONTROL, 32'(m) << CTL_MODE_LSB);
      wr(OFF_POSITION, 32'h0100);
      mv(1, 4);
      rdr(OFF_POSITION);
      chk(d, i[0] ? 32'h0102 : 32'h0104);
      rdr(OFF_CONTROL);
      chk(d & 32'h3C, 32'h20 | (32'(m) << 2));
      mv(0, 4);
      rdr(OFF_POSITION);
      chk(d, 32'h0100);
      rdr(OFF_CONTROL);
      chk(32'(d[5]), 32'h0);
    end
    $display("test done: counting");
    // Every step counts once in x4
    wr(OFF_CONTROL, 32'(MODE_X4_INDEX) << CTL_MODE_LSB);
    for (i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      p = lfsr[15:0];
      n = int'(lfsr[18:16]) + 1;
      up = lfsr[20];
      wr(OFF_POSITION, 32'(p));
      mv(up, n);
      rdr(OFF_POSITION);
      chk(d, 32'(exp_pos(p, n, up)));
    end
    $display("test done: random moves");
    wr(OFF_IRQ_ENABLE, 32'h2);
    wr(OFF_POSITION, 32'h0055);
    mv(1, 1);
    wr(OFF_FLAGS, 32'h7);
    idx_in <= 1;
    mv(1, 1);
    rdr(OFF_POSITION);
    chk(d, 32'h0);
    rdr(OFF_FLAGS);
    chk(d & 32'h2, 32'h2);
    $display("test done: index");
    wr(OFF_CONTROL, 32'(MODE_X4_PERIOD) << CTL_MODE_LSB);
    wr(OFF_LIMIT, 32'h0010);
    wr(OFF_POSITION, 32'h000E);
    wr(OFF_FLAGS, 32'h7);
    mv(1, 3);
    rdr(OFF_POSITION);
    chk(d, 32'h0001);
    rdr(OFF_FLAGS);
    chk(d & 32'h2, 32'h2);
    mv(0, 2);
    rdr(OFF_POSITION);
    chk(d, 32'h000F);
    $display("test done: period");
    // x4 index mode, ratio 1:4, count wraps from FFFF
    wr(OFF_CONTROL, 32'h15);
    wr(OFF_POSITION, 32'hFFFF);
    wr(OFF_FLAGS, 32'h7);
    rdr(OFF_VELOCITY);
    p = d[15:0];
    n = nv;
    mv(1, 8);
    rdr(OFF_VELOCITY);
    chk(32'(d[15:0] - p), 32'h2);
    chk(32'(nv - n), 32'h2);
    rdr(OFF_CONTROL);
    chk(d & 32'h40, 32'h40);
    rdr(OFF_FLAGS);
    chk(d & 32'h5, 32'h5);
    // Velocity measurement off
    wr(OFF_CONTROL, 32'h95);
    n = nv;
    mv(1, 4);
    chk(32'(nv - n), 32'h0);
    $display("test done: velocity");
    for (i = 0; i < 3; i++) begin
      wr(OFF_CONTROL, 32'(um[i]) << CTL_MODE_LSB);
      wr(OFF_POSITION, 32'h0020);
      mv(1, 2);
      rdr(OFF_POSITION);
      chk(d, 32'h0020);
    end
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_CAPTURE, 32'h1);
    chk(32'(cue), 32'h1);
    wr(OFF_CONTROL, 32'(MODE_X4_INDEX) << CTL_MODE_LSB);
    chk(32'(cue), 32'h0);
    chk(32'(ci), 32'h0);
    $display("test done: unused modes and capture");
    give_verdict;
  end
endmodule
